// ### verilog/pin_function_pkg.sv
// constants shared by the indicator and general-purpose pin function select logic
// ============================================================================
package pin_function_pkg;
	// ========================================================================
	// register map, byte addresses on the 32-bit bus
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_GENERAL_IO = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam int unsigned ADDR_BITS = 4;

	// control register fields
	localparam int unsigned CTL_LINK_FN = 0;
	localparam int unsigned CTL_SPEED_FN_LO = 1;
	localparam int unsigned CTL_COL_FN_LO = 3;
	localparam int unsigned CTL_RXD3_FN_LO = 5;
	localparam int unsigned CTL_MEDIA_LO = 7;
	localparam int unsigned CTL_COL_SRC_LO = 9;
	localparam int unsigned CTL_RXD3_SRC_LO = 11;
	localparam int unsigned CTL_WIDTH = 13;
	localparam logic [12:0] CONTROL_RESET = 13'h0000;

	// general io register: values in [2:0], drive enables in [5:3]
	localparam int unsigned GIO_OE_LO = 3;
	localparam int unsigned GIO_WIDTH = 6;
	localparam logic [5:0] GENERAL_IO_RESET = 6'h00;

	// pin function codes
	localparam logic [1:0] FN_DEFAULT = 2'h0;
	localparam logic [1:0] FN_INDICATOR = 2'h1;
	localparam logic [1:0] FN_GENERAL_IO = 2'h2;

	// indicator sources for the reused pins
	localparam logic [1:0] SRC_LINK = 2'h0;
	localparam logic [1:0] SRC_ACTIVITY = 2'h1;
	localparam logic [1:0] SRC_SPEED = 2'h2;
	localparam logic [1:0] SRC_DUPLEX = 2'h3;

	// mac interface modes
	localparam logic [1:0] MAC_MII = 2'h0;
	localparam logic [1:0] MAC_RMII = 2'h1;
	localparam logic [1:0] MAC_RGMII = 2'h2;

	// media signalling selection and result
	localparam logic [1:0] MEDIA_AUTO = 2'h0;
	localparam logic [1:0] MEDIA_10TE = 2'h1;
	localparam logic [1:0] MEDIA_100TX = 2'h2;
	localparam logic [1:0] MEDIA_100FX = 2'h3;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// activity blink: half period in ms, reference clock in kHz
	localparam int unsigned BLINK_HALF_MS = 50;
	localparam int unsigned CLOCK_KHZ = 25000;
	localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLOCK_KHZ;
endpackage

// ### verilog/led_gpio_pin_function_select.sv
// indicator, general io and media select logic with an AXI4-Lite register slave
`timescale 1ns/1ns
module led_gpio_pin_function_select
#(
	parameter int unsigned BLINK_HALF_CYCLES = pin_function_pkg::BLINK_HALF_CYCLES
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [3:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [3:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// link state from the transceiver core
	input wire logic [1:0] mac_mode,
	input wire logic link_up,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic tx_media_busy,
	input wire logic rx_media_busy,
	input wire logic fibre_capable,
	input wire logic rx_data_bit3,
	// media signalling towards the analog front end
	output logic [1:0] media_type,
	output logic signal_detect,
	// indicator and multi-purpose pins
	output logic link_activity_indicator,
	input wire logic speed_indicator_pin_in,
	output logic speed_indicator_pin_out,
	output logic speed_indicator_pin_oe,
	input wire logic collision_pin_in,
	output logic collision_pin_out,
	output logic collision_pin_oe,
	input wire logic receive_data_bit_three_in,
	output logic receive_data_bit_three_out,
	output logic receive_data_bit_three_oe
);
	// ========================================================================
	// register bus
	logic [12:0] control;
	logic [5:0] general_io;
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] status_word;
	logic [31:0] next_rdata;
	logic next_rbad;

	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;

	// address and data may arrive in either order; each is held until both are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			else if (aw_held && w_held)
				aw_held <= 1'b0;
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			else if (aw_held && w_held)
				w_held <= 1'b0;
		end
	end

	// the write commits in the cycle both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			control <= pin_function_pkg::CONTROL_RESET;
			general_io <= pin_function_pkg::GENERAL_IO_RESET;
			bvalid <= 1'b0;
			bresp <= pin_function_pkg::RESP_OKAY;
		end
		else if (aw_held && w_held)
		begin
			bvalid <= 1'b1;
			bresp <= pin_function_pkg::RESP_OKAY;
			case (aw_addr)
				pin_function_pkg::ADDR_CONTROL:
				begin
					if (w_strb[0])
						control[7:0] <= w_data[7:0];
					if (w_strb[1])
						control[12:8] <= w_data[12:8];
				end
				pin_function_pkg::ADDR_GENERAL_IO:
				begin
					if (w_strb[0])
						general_io <= w_data[5:0];
				end
				pin_function_pkg::ADDR_STATUS:
					bresp <= pin_function_pkg::RESP_OKAY;
				default:
					bresp <= pin_function_pkg::RESP_SLVERR;
			endcase
		end
		else if (bvalid && bready)
			bvalid <= 1'b0;
	end

	always_comb
	begin
		next_rbad = 1'b0;
		case (araddr)
			pin_function_pkg::ADDR_CONTROL:
				next_rdata = {19'h00000, control};
			pin_function_pkg::ADDR_GENERAL_IO:
				next_rdata = {26'h0000000, general_io};
			pin_function_pkg::ADDR_STATUS:
				next_rdata = status_word;
			default:
			begin
				next_rdata = 32'h00000000;
				next_rbad = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= pin_function_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= next_rbad ? pin_function_pkg::RESP_SLVERR : pin_function_pkg::RESP_OKAY;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	// ========================================================================
	// configuration fields
	logic link_fn_activity;
	logic [1:0] speed_fn;
	logic [1:0] col_fn;
	logic [1:0] rxd3_fn;
	logic [1:0] media_sel;
	logic [1:0] col_src;
	logic [1:0] rxd3_src;

	assign link_fn_activity = control[pin_function_pkg::CTL_LINK_FN];
	assign speed_fn = control[pin_function_pkg::CTL_SPEED_FN_LO +: 2];
	assign col_fn = control[pin_function_pkg::CTL_COL_FN_LO +: 2];
	assign rxd3_fn = control[pin_function_pkg::CTL_RXD3_FN_LO +: 2];
	assign media_sel = control[pin_function_pkg::CTL_MEDIA_LO +: 2];
	assign col_src = control[pin_function_pkg::CTL_COL_SRC_LO +: 2];
	assign rxd3_src = control[pin_function_pkg::CTL_RXD3_SRC_LO +: 2];

	// ========================================================================
	// media signalling selection
	logic [1:0] next_media;

	always_comb
	begin
		if (media_sel != pin_function_pkg::MEDIA_AUTO)
			next_media = media_sel;
		else if (fibre_capable)
			next_media = pin_function_pkg::MEDIA_100FX;
		else if (speed_100)
			next_media = pin_function_pkg::MEDIA_100TX;
		else
			next_media = pin_function_pkg::MEDIA_10TE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			media_type <= pin_function_pkg::MEDIA_10TE;
		else
			media_type <= next_media;
	end

	// ========================================================================
	// activity blink timebase; a slow fixed half period keeps the blink visible
	logic [31:0] blink_count;
	logic blink_phase;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			blink_count <= 32'h00000000;
			blink_phase <= 1'b0;
		end
		else if (blink_count >= 32'(BLINK_HALF_CYCLES - 1))
		begin
			blink_count <= 32'h00000000;
			blink_phase <= !blink_phase;
		end
		else
			blink_count <= blink_count + 32'h00000001;
	end

	// ========================================================================
	// indicator levels
	logic traffic;
	logic link_led;
	logic activity_led;
	logic collision_level;
	logic col_led;
	logic rxd3_led;
	logic fibre;

	assign traffic = tx_active || rx_active;
	assign activity_led = link_up && !(traffic && blink_phase);
	assign link_led = link_fn_activity ? activity_led : link_up;
	assign collision_level = !full_duplex && tx_media_busy && rx_media_busy;
	assign fibre = media_type == pin_function_pkg::MEDIA_100FX;

	function automatic logic pick_source(input logic [1:0] src, input logic act);
		case (src)
			pin_function_pkg::SRC_LINK:
				pick_source = link_up;
			pin_function_pkg::SRC_ACTIVITY:
				pick_source = act;
			pin_function_pkg::SRC_SPEED:
				pick_source = link_up && speed_100;
			default:
				pick_source = link_up && full_duplex;
		endcase
	endfunction

	assign col_led = pick_source(col_src, activity_led);
	assign rxd3_led = pick_source(rxd3_src, activity_led);

	// ========================================================================
	// pin drivers, all registered
	logic next_col_out;
	logic next_col_oe;
	logic next_rxd3_out;
	logic next_rxd3_oe;
	logic next_speed_out;
	logic next_speed_oe;

	always_comb
	begin
		next_speed_out = 1'b0;
		next_speed_oe = 1'b0;
		if (fibre)
			next_speed_oe = 1'b0;
		else if (speed_fn == pin_function_pkg::FN_INDICATOR)
		begin
			next_speed_oe = 1'b1;
			next_speed_out = link_up && speed_100;
		end
		else if (speed_fn == pin_function_pkg::FN_GENERAL_IO)
		begin
			next_speed_oe = general_io[pin_function_pkg::GIO_OE_LO];
			next_speed_out = general_io[0];
		end
	end

	always_comb
	begin
		next_col_out = 1'b0;
		next_col_oe = 1'b0;
		if (col_fn == pin_function_pkg::FN_GENERAL_IO)
		begin
			next_col_oe = general_io[pin_function_pkg::GIO_OE_LO + 1];
			next_col_out = general_io[1];
		end
		else if (col_fn == pin_function_pkg::FN_INDICATOR && mac_mode == pin_function_pkg::MAC_MII)
		begin
			// in half duplex the pin is still needed for collision
			next_col_oe = 1'b1;
			next_col_out = full_duplex ? col_led : collision_level;
		end
		else if (col_fn == pin_function_pkg::FN_INDICATOR)
		begin
			next_col_oe = 1'b1;
			next_col_out = col_led;
		end
		else if (mac_mode == pin_function_pkg::MAC_MII)
		begin
			next_col_oe = 1'b1;
			next_col_out = collision_level;
		end
	end

	always_comb
	begin
		next_rxd3_out = rx_data_bit3;
		next_rxd3_oe = 1'b1;
		if (mac_mode != pin_function_pkg::MAC_RMII)
		begin
			next_rxd3_out = rx_data_bit3;
			next_rxd3_oe = 1'b1;
		end
		else if (rxd3_fn == pin_function_pkg::FN_INDICATOR)
		begin
			next_rxd3_out = rxd3_led;
			next_rxd3_oe = 1'b1;
		end
		else if (rxd3_fn == pin_function_pkg::FN_GENERAL_IO)
		begin
			next_rxd3_out = general_io[2];
			next_rxd3_oe = general_io[pin_function_pkg::GIO_OE_LO + 2];
		end
		else
		begin
			next_rxd3_out = 1'b0;
			next_rxd3_oe = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link_activity_indicator <= 1'b0;
			speed_indicator_pin_out <= 1'b0;
			speed_indicator_pin_oe <= 1'b0;
			collision_pin_out <= 1'b0;
			collision_pin_oe <= 1'b0;
			receive_data_bit_three_out <= 1'b0;
			receive_data_bit_three_oe <= 1'b0;
			signal_detect <= 1'b0;
		end
		else
		begin
			link_activity_indicator <= link_led;
			speed_indicator_pin_out <= next_speed_out;
			speed_indicator_pin_oe <= next_speed_oe;
			collision_pin_out <= next_col_out;
			collision_pin_oe <= next_col_oe;
			receive_data_bit_three_out <= next_rxd3_out;
			receive_data_bit_three_oe <= next_rxd3_oe;
			signal_detect <= fibre && speed_indicator_pin_in;
		end
	end

	assign status_word = {22'h000000, signal_detect, media_type, receive_data_bit_three_in,
		collision_pin_in, speed_indicator_pin_in, blink_phase, full_duplex, speed_100, link_up};

	// ========================================================================
	// checks
	link_default_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!link_fn_activity && !$rose(link_fn_activity) |=> link_activity_indicator == $past(link_up))
		else $error("link indicator does not follow link state");
	activity_blink_a: assert property (@(posedge aclk) disable iff (!aresetn)
		link_fn_activity && link_up && !traffic |=> link_activity_indicator)
		else $error("activity indicator off with idle link up");
	speed_tristate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		speed_fn == pin_function_pkg::FN_DEFAULT |=> !speed_indicator_pin_oe)
		else $error("speed pin driven in default function");
	speed_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
		speed_fn == pin_function_pkg::FN_INDICATOR && !fibre && link_up
		|=> speed_indicator_pin_oe && speed_indicator_pin_out == $past(speed_100))
		else $error("speed indicator wrong");
	fibre_detect_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fibre |=> !speed_indicator_pin_oe && signal_detect == $past(speed_indicator_pin_in))
		else $error("signal detect not taken in fibre mode");
	collision_duplex_a: assert property (@(posedge aclk) disable iff (!aresetn)
		col_fn == pin_function_pkg::FN_DEFAULT && mac_mode == pin_function_pkg::MAC_MII
		|=> collision_pin_oe && collision_pin_out == $past(collision_level))
		else $error("collision pin wrong");
	col_general_a: assert property (@(posedge aclk) disable iff (!aresetn)
		col_fn == pin_function_pkg::FN_GENERAL_IO
		|=> collision_pin_out == $past(general_io[1]))
		else $error("collision pin not general io");
	rxd3_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mac_mode != pin_function_pkg::MAC_RMII
		|=> receive_data_bit_three_oe && receive_data_bit_three_out == $past(rx_data_bit3))
		else $error("receive bit three repurposed outside RMII");
	media_forced_a: assert property (@(posedge aclk) disable iff (!aresetn)
		media_sel != pin_function_pkg::MEDIA_AUTO ##1 $stable(media_sel)
		|=> media_type == $past(media_sel, 2))
		else $error("forced media type not applied");
	blink_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
		blink_count < 32'(BLINK_HALF_CYCLES))
		else $error("blink counter past half period");
endmodule

// ### sim/pin_far_side.sv
// far-side model of the multi-purpose pins: pulls and optical signal detect
`timescale 1ns/1ns
module pin_far_side
(
	// device pin drivers
	input wire logic speed_out,
	input wire logic speed_oe,
	input wire logic col_out,
	input wire logic col_oe,
	input wire logic rxd3_out,
	input wire logic rxd3_oe,
	// optical transceiver
	input wire logic sd_en,
	input wire logic sd_level,
	// wire levels fed back to the pins
	output logic speed_wire,
	output logic col_wire,
	output logic rxd3_wire
);
	// ======================================================================
	// wire resolution
	// an undriven pin settles to its pull, or the speed pin to sd_level while sd_en is set; never to the last driven value
	assign speed_wire = speed_oe ? speed_out : (sd_en ? sd_level : 1'b0);
	assign col_wire = col_oe ? col_out : 1'b1;
	assign rxd3_wire = rxd3_oe ? rxd3_out : 1'b0;
endmodule

// ### sim/led_gpio_pin_function_select_test.sv
// self-checking bench for the pin function select block
`timescale 1ns/1ns
module led_gpio_pin_function_select_test;
	// ======================================================================
	// signals
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic bvalid, arready, rvalid, signal_detect, led, sd_en, sd_level;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] mac_mode, bresp, rresp, media_type, resp;
	logic link_up, speed_100, full_duplex, tx_active, rx_active, tx_busy, rx_busy;
	logic fibre_capable, rx_data_bit3;
	logic sp_in, sp_out, sp_oe, col_in, col_out, col_oe, rx3_in, rx3_out, rx3_oe;
	int n_mismatch, tests_run, cycles, hi;

	led_gpio_pin_function_select #(.BLINK_HALF_CYCLES(4)) dut
	(
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.mac_mode(mac_mode), .link_up(link_up), .speed_100(speed_100),
		.full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
		.tx_media_busy(tx_busy), .rx_media_busy(rx_busy),
		.fibre_capable(fibre_capable), .rx_data_bit3(rx_data_bit3),
		.media_type(media_type), .signal_detect(signal_detect),
		.link_activity_indicator(led),
		.speed_indicator_pin_in(sp_in), .speed_indicator_pin_out(sp_out),
		.speed_indicator_pin_oe(sp_oe),
		.collision_pin_in(col_in), .collision_pin_out(col_out), .collision_pin_oe(col_oe),
		.receive_data_bit_three_in(rx3_in), .receive_data_bit_three_out(rx3_out),
		.receive_data_bit_three_oe(rx3_oe)
	);

	pin_far_side far
	(
		.speed_out(sp_out), .speed_oe(sp_oe), .col_out(col_out), .col_oe(col_oe),
		.rxd3_out(rx3_out), .rxd3_oe(rx3_oe), .sd_en(sd_en), .sd_level(sd_level),
		.speed_wire(sp_in), .col_wire(col_in), .rxd3_wire(rx3_in)
	);

	// ======================================================================
	// clock and time limit
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	// ======================================================================
	// common tasks
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// pin outputs trail their cause by one edge; sample between edges
	task automatic settle();
		repeat (2) @(posedge aclk);
		@(negedge aclk);
	endtask

	// handshakes are judged between edges, so the edge itself never races
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, b_hs;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs)
		begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bready && bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw_hs)
				awvalid <= 1'b0;
			if (w_hs)
				wvalid <= 1'b0;
			if (b_hs)
				bready <= 1'b0;
		end
	endtask

	task automatic axr(input logic [3:0] a);
		logic ar_hs, r_hs;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs)
		begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs = rready && rvalid;
			resp = rresp;
			rd = rdata;
			@(posedge aclk);
			if (ar_hs)
				arvalid <= 1'b0;
			if (r_hs)
				rready <= 1'b0;
		end
	endtask

	task automatic wc(input logic [31:0] d);
		axw(pin_function_pkg::ADDR_CONTROL, d);
		chk(32'(resp), 32'(pin_function_pkg::RESP_OKAY));
		settle();
	endtask

	// ======================================================================
	// scenarios
	task automatic t_reset();
		axr(pin_function_pkg::ADDR_CONTROL);
		chk(rd, 32'h0000_0000);
		axr(pin_function_pkg::ADDR_STATUS);
		chk(32'(rd[8:7]), 32'(pin_function_pkg::MEDIA_10TE));
		chk(32'(sp_oe), 32'h0);
		chk(32'(led), 32'h0);
		@(posedge aclk);
		link_up <= 1'b1;
		settle();
		chk(32'(led), 32'h1);
	endtask

	task automatic t_activity();
		wc(32'h0000_0001);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge aclk);
			tx_active <= (k == 0);
			rx_active <= (k == 1);
			settle();
			hi = 0;
			// sixteen cycles span two whole blink periods of eight
			repeat (16)
			begin
				@(negedge aclk);
				hi += int'(led);
			end
			chk(32'(hi), (k == 2) ? 32'h10 : 32'h8);
		end
	endtask

	task automatic t_speed();
		wc(32'h0000_0002);
		for (int s = 0; s < 2; s++)
		begin
			@(posedge aclk);
			speed_100 <= s[0];
			settle();
			chk(32'({sp_oe, sp_out}), 32'({1'b1, s[0]}));
		end
	endtask

	task automatic t_general();
		@(posedge aclk);
		mac_mode <= pin_function_pkg::MAC_RMII;
		wc(32'h0000_0054);
		axw(pin_function_pkg::ADDR_GENERAL_IO, 32'h0000_003D);
		settle();
		chk(32'({sp_oe, col_oe, rx3_oe, rx3_out, col_out, sp_out}), 32'h3D);
		axr(pin_function_pkg::ADDR_STATUS);
		chk(32'(rd[6:4]), 32'h5);
		axw(pin_function_pkg::ADDR_GENERAL_IO, 32'h0000_0000);
		axr(pin_function_pkg::ADDR_STATUS);
		chk(32'({sp_oe, col_oe, rx3_oe, rd[6:4]}), 32'h02);
	endtask

	task automatic t_media();
		for (int m = 1; m < 4; m++)
		begin
			wc(32'(m) << 7);
			chk(32'(media_type), 32'(m));
		end
		wc(32'h0000_0182);
		@(posedge aclk);
		sd_en <= 1'b1;
		sd_level <= 1'b1;
		settle();
		chk(32'({sp_oe, signal_detect}), 32'h1);
		@(posedge aclk);
		sd_level <= 1'b0;
		settle();
		chk(32'({sp_oe, signal_detect}), 32'h0);
		wc(32'h0000_0000);
		for (int a = 0; a < 3; a++)
		begin
			@(posedge aclk);
			fibre_capable <= (a == 0);
			speed_100 <= (a == 1);
			settle();
			chk(32'(media_type), 32'(3 - a));
		end
	endtask

	task automatic t_collision();
		@(posedge aclk);
		mac_mode <= pin_function_pkg::MAC_MII;
		for (int c = 0; c < 4; c++)
		begin
			@(posedge aclk);
			full_duplex <= c[1];
			tx_busy <= 1'b1;
			rx_busy <= !c[0];
			settle();
			chk(32'({col_oe, col_out}), (c == 0) ? 32'h3 : 32'h2);
		end
		wc(32'h0000_0008);
		for (int md = 0; md < 3; md++)
		begin
			@(posedge aclk);
			mac_mode <= 2'(md);
			link_up <= 1'b0;
			settle();
			chk(32'({col_oe, col_out}), 32'h2);
			@(posedge aclk);
			link_up <= 1'b1;
			settle();
			chk(32'({col_oe, col_out}), 32'h3);
		end
	endtask

	task automatic t_rx_bit3();
		wc(32'h0000_0040);
		for (int md = 0; md < 4; md++)
		begin
			@(posedge aclk);
			mac_mode <= md[0] ? pin_function_pkg::MAC_RGMII : pin_function_pkg::MAC_MII;
			rx_data_bit3 <= md[1];
			settle();
			chk(32'({rx3_oe, rx3_out}), 32'({1'b1, md[1]}));
		end
		@(posedge aclk);
		mac_mode <= pin_function_pkg::MAC_RMII;
		wc(32'h0000_0020);
		chk(32'({rx3_oe, rx3_out}), 32'h3);
		wc(32'h0000_0000);
		chk(32'(rx3_oe), 32'h0);
	endtask

	task automatic t_unmapped();
		axw(4'hC, 32'hFFFF_FFFF);
		chk(32'(resp), 32'(pin_function_pkg::RESP_SLVERR));
		axr(4'hC);
		chk({rd[31:2], resp}, 32'(pin_function_pkg::RESP_SLVERR));
	endtask

	// ======================================================================
	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sd_en, sd_level} = '0;
		{awaddr, araddr, wdata, mac_mode} = '0;
		{link_up, speed_100, full_duplex, tx_active, rx_active, tx_busy, rx_busy} = '0;
		{fibre_capable, rx_data_bit3, n_mismatch, tests_run, cycles} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_activity();
		t_speed();
		t_general();
		t_media();
		t_collision();
		t_rx_bit3();
		t_unmapped();
		stop_test();
	end
endmodule
